// ==== core/sbpr_console_tx.sv ====
// Console side sender: APB registers, packet assembly and serial framing
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sbpr_console_tx #(
   parameter int unsigned FLASH_CYCLES = sbpr_pkg::FLASH_CYCLES_DEF
) (
   input  wire logic                      clk,
   input  wire logic                      resetn,
   input  wire sbpr_pkg::sbpr_apb_req_type apb_req,
   output logic [31:0]                    prdata,
   output logic                           pready,
   output logic                           pslverr,
   output logic                           line_out,
   output logic                           line_oe
);
   import sbpr_pkg::*;

   function automatic logic pay_hit(input logic [11:0] a);
      return (a[11:6] == 6'h00) && (a[5:4] == 2'h1 || a[5:4] == 2'h2)
             && (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
   endfunction

   logic [31:0]        prdata_q;
   logic               pready_q;
   logic               pslverr_q;
   logic [2:0]         ctrl_q;
   logic [1:0]         urgent_q;
   logic [7:0]         pay_q [2][PAY_BYTES];
   logic [31:0]        flash_cnt_q;
   logic               phase_q;
   sbpr_state_type     st_q;
   logic               cur_pkt_q;
   logic               last_pkt_q;
   logic [3:0]         byte_idx_q;
   logic [7:0]         sum_q;
   logic [10:0]        shreg_q;
   logic [3:0]         bit_cnt_q;
   logic [9:0]         baud_cnt_q;
   logic               line_q;
   logic               oe_q;
   logic [15:0]        sent_q;
   logic [31:0]        rd_word;

   // Bus decode
   wire logic [11:0]   addr     = apb_req.paddr;
   wire logic          setup    = apb_req.psel & ~apb_req.penable;
   wire logic          access   = apb_req.psel & apb_req.penable & pready_q;
   wire logic          wr_en    = access & apb_req.pwrite;
   wire logic          hit_pay  = pay_hit(addr);
   wire logic          pay_pkt  = addr[5];
   wire logic [1:0]    pay_word = addr[3:2];
   wire logic          mapped   = hit_pay || addr == REG_CTRL || addr == REG_STATUS
                                  || addr == REG_URGENT;
   wire logic [1:0]    urg_set  = (wr_en && addr == REG_URGENT) ? apb_req.pwdata[1:0] : 2'h0;

   // Packet selection: urgent requests first, else alternate
   wire logic          want     = ctrl_q[CTRL_EN] | (|urgent_q);
   wire logic          sel_pkt  = urgent_q[0] ? 1'b0 : (urgent_q[1] ? 1'b1 : ~last_pkt_q);
   wire logic          start    = (st_q == SBPR_IDLE) && want;
   wire logic [1:0]    urg_clr  = start ? (sel_pkt ? 2'h2 : 2'h1) : 2'h0;

   // Byte to send
   wire logic [3:0]    pay_k    = (byte_idx_q == 4'h0 || byte_idx_q == LAST_IDX) ?
                                  4'h0 : byte_idx_q - 4'h1;
   wire logic          flash_gc = ctrl_q[CTRL_FLASH_GC] && !cur_pkt_q && pay_k == GC_SEP_K;
   wire logic          flash_to = ctrl_q[CTRL_FLASH_TO] && cur_pkt_q && pay_k == SC_TOSTAT_K;
   wire logic [7:0]    sep_code = phase_q ? CODE_SEP_ON : CODE_SPACE;
   wire logic [7:0]    pay_byte = (flash_gc || flash_to) ? sep_code : pay_q[cur_pkt_q][pay_k];
   wire logic [7:0]    addr_byte = cur_pkt_q ? ADDR_SC : ADDR_GC;
   wire logic [7:0]    byte_val = (byte_idx_q == 4'h0) ? addr_byte :
                                  (byte_idx_q == LAST_IDX) ? {1'b0, sum_q[6:0]} :
                                  pay_byte;
   wire logic [10:0]   frame    = {1'b1, ~^byte_val, byte_val, 1'b0};
   wire logic          bit_tick = baud_cnt_q == 10'(BIT_CYCLES - 1);
   wire logic          last_bit = bit_cnt_q == 4'(FRAME_BITS - 1);

   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign line_out = line_q;
   assign line_oe  = oe_q;

   always_comb begin
      rd_word = 32'h0;
      if (hit_pay) begin
         for (int k = 0; k < 4; k++) begin
            if (int'(pay_word) * 4 + k < PAY_BYTES) begin
               rd_word[8*k +: 8] = pay_q[pay_pkt][int'(pay_word) * 4 + k];
            end
         end
      end else if (addr == REG_CTRL) begin
         rd_word[2:0] = ctrl_q;
      end else if (addr == REG_URGENT) begin
         rd_word[1:0] = urgent_q;
      end else if (addr == REG_STATUS) begin
         rd_word[ST_BUSY]             = st_q != SBPR_IDLE;
         rd_word[ST_CUR]              = cur_pkt_q;
         rd_word[ST_URG_LO +: 2]      = urgent_q;
         rd_word[ST_CNT_LO +: 16]     = sent_q;
      end
   end

   // APB slave: one wait-free access phase
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
         prdata_q  <= setup ? rd_word : 32'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_q   <= CTRL_RESET;
         urgent_q <= 2'h0;
      end else begin
         if (wr_en && addr == REG_CTRL) begin
            ctrl_q <= apb_req.pwdata[2:0];
         end
         urgent_q <= (urgent_q & ~urg_clr) | urg_set;
      end
   end

   // Payload store; idle fields default to space, top bit forced low
   always_ff @(posedge clk) begin
      for (int p = 0; p < 2; p++) begin
         for (int b = 0; b < PAY_BYTES; b++) begin
            if (!resetn) begin
               pay_q[p][b] <= CODE_SPACE;
            end else if (wr_en && hit_pay && pay_pkt == 1'(p) && int'(pay_word) == b / 4) begin
               pay_q[p][b] <= {1'b0, apb_req.pwdata[8*(b%4) +: 7]};
            end
         end
      end
   end

   // Separator flash phase
   always_ff @(posedge clk) begin
      if (!resetn) begin
         flash_cnt_q <= 32'h0;
         phase_q     <= 1'b1;
      end else if (flash_cnt_q == 32'(FLASH_CYCLES - 1)) begin
         flash_cnt_q <= 32'h0;
         phase_q     <= ~phase_q;
      end else begin
         flash_cnt_q <= flash_cnt_q + 32'h1;
      end
   end

   // Packet and frame sequencer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_q       <= SBPR_IDLE;
         cur_pkt_q  <= 1'b0;
         last_pkt_q <= 1'b1;
         byte_idx_q <= 4'h0;
         sum_q      <= 8'h0;
         shreg_q    <= 11'h7ff;
         bit_cnt_q  <= 4'h0;
         baud_cnt_q <= 10'h0;
         line_q     <= 1'b1;
         oe_q       <= 1'b0;
         sent_q     <= 16'h0;
      end else begin
         unique case (st_q)
            SBPR_IDLE: begin
               if (start) begin
                  cur_pkt_q  <= sel_pkt;
                  byte_idx_q <= 4'h0;
                  sum_q      <= 8'h0;
                  st_q       <= SBPR_LOAD;
               end
            end
            SBPR_LOAD: begin
               shreg_q    <= frame;
               line_q     <= frame[0];
               oe_q       <= 1'b1;
               sum_q      <= sum_q + byte_val;
               bit_cnt_q  <= 4'h0;
               baud_cnt_q <= 10'h0;
               st_q       <= SBPR_SHIFT;
            end
            SBPR_SHIFT: begin
               if (!bit_tick) begin
                  baud_cnt_q <= baud_cnt_q + 10'h1;
               end else if (!last_bit) begin
                  baud_cnt_q <= 10'h0;
                  shreg_q    <= {1'b1, shreg_q[10:1]};
                  line_q     <= shreg_q[1];
                  bit_cnt_q  <= bit_cnt_q + 4'h1;
               end else if (byte_idx_q == LAST_IDX) begin
                  // Back-to-back cycling keeps the board well inside its blank timeout
                  oe_q       <= 1'b0;
                  last_pkt_q <= cur_pkt_q;
                  sent_q     <= sent_q + 16'h1;
                  st_q       <= SBPR_IDLE;
               end else begin
                  byte_idx_q <= byte_idx_q + 4'h1;
                  st_q       <= SBPR_LOAD;
               end
            end
         endcase
      end
   end

   // Independent sum of bytes actually framed, for checking only
   logic [7:0] acc_q;
   wire logic  frame_first = st_q == SBPR_SHIFT && bit_cnt_q == 4'h0 && baud_cnt_q == 10'h0;
   always_ff @(posedge clk) begin
      if (!resetn || st_q == SBPR_IDLE) begin
         acc_q <= 8'h0;
      end else if (frame_first && byte_idx_q != LAST_IDX) begin
         acc_q <= acc_q + shreg_q[8:1];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_frame_start;
      st_q == SBPR_LOAD ##1 st_q == SBPR_SHIFT;
   endsequence

   sequence s_first_bit;
      frame_first;
   endsequence

   AST_BIT_HOLD: assert property ((st_q == SBPR_SHIFT && !bit_tick) |=> $stable(line_q))
      else $error("line changed inside a bit period");
   AST_START_BIT: assert property (s_frame_start |-> !line_q && line_oe)
      else $error("frame did not open with a driven start bit");
   AST_ODD_PARITY: assert property (s_first_bit |-> (^shreg_q[9:1]) == 1'b1)
      else $error("parity is not odd");
   AST_FRAME_ENDS: assert property (s_first_bit |-> shreg_q[10] && !shreg_q[0])
      else $error("start or stop bit wrong");
   AST_PKT_LEN: assert property ($rose(st_q == SBPR_IDLE) |-> byte_idx_q == LAST_IDX)
      else $error("packet did not hold twelve bytes");
   AST_URGENT: assert property ((st_q == SBPR_IDLE && urgent_q == 2'h2) |=> cur_pkt_q)
      else $error("urgent packet not taken next");
   AST_ADDR_TOP: assert property ((s_first_bit and byte_idx_q == 4'h0) |-> shreg_q[8])
      else $error("address byte lacks top bit");
   AST_PAYLOAD_TOP: assert property ((s_first_bit and byte_idx_q != 4'h0) |-> !shreg_q[8])
      else $error("payload or check byte has top bit set");
   AST_CHECK: assert property ((s_first_bit and byte_idx_q == LAST_IDX) |->
                               shreg_q[8:1] == {1'b0, acc_q[6:0]})
      else $error("check byte does not match sum");
   // Phase may toggle on the load edge, so compare with its value at load
   AST_SEP_FLASH: assert property ((st_q == SBPR_LOAD && flash_gc) |=>
                                   shreg_q[8:1] == ($past(phase_q) ? 8'h3a : 8'h20))
      else $error("game separator not flashed");
   AST_TO_FLASH: assert property ((st_q == SBPR_LOAD && flash_to) |=>
                                  shreg_q[8:1] == ($past(phase_q) ? 8'h3a : 8'h20))
      else $error("timeout separator not flashed");

   // Sequencer bookkeeping
   AST_IDLE_REST: assert property ((st_q == SBPR_IDLE) |-> line_q && !oe_q)
      else $error("line not released high while idle");
   AST_LOAD_ONCE: assert property ((st_q == SBPR_LOAD) |=> (st_q == SBPR_SHIFT))
      else $error("load lasted more than one cycle");
   AST_BAUD_RANGE: assert property ((st_q == SBPR_SHIFT) |->
                                    baud_cnt_q < 10'(BIT_CYCLES) && bit_cnt_q < 4'(FRAME_BITS))
      else $error("bit or baud counter out of range");
   AST_URG_DROP: assert property ((start && urgent_q == 2'h2 && urg_set == 2'h0) |=>
                                  urgent_q == 2'h0)
      else $error("urgent request not cleared when taken");
   AST_ADDR_PICK: assert property ((s_first_bit and byte_idx_q == 4'h0) |->
                                   shreg_q[8:1] == (cur_pkt_q ? ADDR_SC : ADDR_GC))
      else $error("address byte does not match packet");
   AST_SENT_STEP: assert property ($rose(st_q == SBPR_IDLE) |->
                                   sent_q == $past(sent_q) + 16'h1)
      else $error("sent count did not step once per packet");
endmodule // sbpr_console_tx

`default_nettype wire

// ==== shared/sbpr_pkg.sv ====
// Constants and types for the scoreboard packet sender
package sbpr_pkg;
   // APB bus
   localparam int unsigned       APB_AW        = 12;
   localparam logic [11:0]       REG_CTRL      = 12'h000;
   localparam logic [11:0]       REG_STATUS    = 12'h004;
   localparam logic [11:0]       REG_URGENT    = 12'h008;
   localparam logic [11:0]       REG_PAY0      = 12'h010;
   localparam logic [11:0]       REG_PAY1      = 12'h020;
   // Control bits
   localparam int unsigned       CTRL_EN       = 0;
   localparam int unsigned       CTRL_FLASH_GC = 1;
   localparam int unsigned       CTRL_FLASH_TO = 2;
   localparam logic [2:0]        CTRL_RESET    = 3'h0;
   // Status bits
   localparam int unsigned       ST_BUSY       = 0;
   localparam int unsigned       ST_CUR        = 1;
   localparam int unsigned       ST_URG_LO     = 2;
   localparam int unsigned       ST_CNT_LO     = 16;
   // Line timing
   localparam int unsigned       CLK_HZ        = 10_000_000;
   localparam int unsigned       BIT_RATE      = 19200;
   localparam int unsigned       BIT_CYCLES    = CLK_HZ / BIT_RATE;
   localparam int unsigned       FRAME_BITS    = 11;
   localparam int unsigned       FLASH_MS      = 500;
   localparam int unsigned       FLASH_CYCLES_DEF = CLK_HZ / 1000 * FLASH_MS;
   // Packet layout
   localparam int unsigned       PAY_BYTES     = 10;
   localparam logic [3:0]        LAST_IDX      = 4'hb;
   localparam logic [7:0]        ADDR_GC       = 8'h80;
   localparam logic [7:0]        ADDR_SC       = 8'h81;
   localparam logic [3:0]        GC_SEP_K      = 4'h4;
   localparam logic [3:0]        SC_TOSTAT_K   = 4'h3;
   localparam logic [7:0]        CODE_SPACE    = 8'h20;
   localparam logic [7:0]        CODE_SEP_ON   = 8'h3a;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [11:0]       paddr;
      logic [31:0]       pwdata;
   } sbpr_apb_req_type;

   typedef enum logic [2:0] {
      SBPR_IDLE  = 3'b001,
      SBPR_LOAD  = 3'b010,
      SBPR_SHIFT = 3'b100
   } sbpr_state_type;
endpackage

// ==== tb/sbpr_rx_model.sv ====
// Scoreboard receiver model: frames bytes, checks packets, decodes shot-clock fields
`timescale 1ns/1ps
`default_nettype none

module sbpr_rx_model (
   input  wire logic  clk,
   input  wire logic  line,
   output logic       ok_p,
   output logic       bad_p,
   output logic [1:0] strip,
   output logic       shot_run
);
   import sbpr_pkg::*;
   logic [7:0] pkt [12];
   logic [7:0] sum;
   logic       err;
   logic       e;
   logic [1:0] yel_tenths;
   logic       to_sep;
   logic [6:0] shot_seg [2];
   logic [6:0] gc_seg [4];
   logic       gc_sep;
   logic       poss;
   logic [1:0] lamps;
   logic [2:0] chrono;
   logic       blank;
   int         idle_cnt = 0;
   localparam int BLANK_CYCLES = CLK_HZ * 5;

   // Quiet line for the blank time turns the board off; any start bit revives it
   always @(posedge clk) begin
      if (line === 1'b0) begin
         idle_cnt <= 0;
      end else if (idle_cnt < BLANK_CYCLES) begin
         idle_cnt <= idle_cnt + 1;
      end
   end
   assign blank = (idle_cnt >= BLANK_CYCLES);

   // Segment order g f e d c b a
   function automatic logic [6:0] seg7(input logic [7:0] c);
      case (c)
         8'h30: return 7'h3f;
         8'h31: return 7'h06;
         8'h32: return 7'h5b;
         8'h33: return 7'h4f;
         8'h34: return 7'h66;
         8'h35: return 7'h6d;
         8'h36: return 7'h7d;
         8'h37: return 7'h07;
         8'h38: return 7'h7f;
         8'h39: return 7'h6f;
         8'h3a: return 7'h77;
         8'h3b: return 7'h7c;
         8'h3c: return 7'h39;
         8'h3d: return 7'h5e;
         8'h3e: return 7'h79;
         8'h3f: return 7'h71;
         8'h41: return 7'h04;
         8'h42: return 7'h0c;
         8'h43: return 7'h0e;
         8'h44: return 7'h1c;
         8'h45: return 7'h40;
         8'h46: return 7'h3e;
         8'h47: return 7'h73;
         8'h48: return 7'h58;
         8'h49: return 7'h63;
         8'h4a: return 7'h76;
         8'h4b: return 7'h74;
         8'h4c: return 7'h38;
         8'h4d: return 7'h78;
         8'h4e: return 7'h6e;
         default: return 7'h00;
      endcase
   endfunction

   // One frame, sampled at bit centres
   task automatic get_byte(output logic [7:0] b, output logic fe);
      logic p;
      while (line !== 1'b0) @(posedge clk);
      repeat (BIT_CYCLES / 2) @(posedge clk);
      fe = (line !== 1'b0);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYCLES) @(posedge clk);
         b[i] = line;
      end
      repeat (BIT_CYCLES) @(posedge clk);
      p = line;
      fe = fe | ((^{b, p}) !== 1'b1);
      repeat (BIT_CYCLES) @(posedge clk);
      fe = fe | (line !== 1'b1);
   endtask

   initial begin
      ok_p = 1'b0;
      bad_p = 1'b0;
      strip = 2'h0;
      shot_run = 1'b0;
      forever begin
         get_byte(pkt[0], err);
         // Bytes without the top bit cannot open a packet
         if (pkt[0][7] === 1'b1) begin
            sum = pkt[0];
            for (int k = 1; k < 12; k++) begin
               get_byte(pkt[k], e);
               err = err | e | (pkt[k][7] !== 1'b0);
               if (k < 11) sum = sum + pkt[k];
            end
            err = err | ({1'b0, sum[6:0]} !== pkt[11]);
            @(posedge clk);
            if (!err && pkt[0] === ADDR_SC) begin
               strip <= (pkt[10] === CODE_SPACE) ? 2'h0 : pkt[10][1:0];
               shot_run <= (pkt[9] === 8'h31);
               yel_tenths <= (pkt[1] === CODE_SPACE) ? 2'h0 : pkt[1][1:0];
               shot_seg[0] <= seg7(pkt[2]);
               shot_seg[1] <= seg7(pkt[3]);
               to_sep <= (pkt[4] === CODE_SEP_ON);
            end
            if (!err && pkt[0] === ADDR_GC) begin
               // Pairs carry seconds and tenths instead when tenths are shown
               for (int k = 0; k < 4; k++) gc_seg[k] <= seg7(pkt[k + 1]);
               gc_sep <= (pkt[5] === CODE_SEP_ON);
               poss <= (pkt[6] === 8'h70);
               lamps <= (pkt[7] === 8'h40) ? 2'h0 : pkt[7][1:0];
               chrono <= (pkt[8] === 8'h47) ? 3'h1 : (pkt[8] === 8'h50) ? 3'h2 :
                         (pkt[8] === 8'h54) ? 3'h3 : (pkt[8] === 8'h4f) ? 3'h4 : 3'h0;
            end
            ok_p <= !err;
            bad_p <= err;
            @(posedge clk);
            ok_p <= 1'b0;
            bad_p <= 1'b0;
         end
      end
   end
endmodule // sbpr_rx_model

`default_nettype wire

// ==== tb/test_sbpr_console_tx.sv ====
// Bench for the console sender: APB map and one urgent shot-clock packet
`timescale 1ns/1ps
`default_nettype none

module test_sbpr_console_tx;
   import sbpr_pkg::*;
   logic             clk;
   logic             resetn;
   sbpr_apb_req_type req;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic             line_out;
   logic             line_oe;
   wire logic        line;
   logic             ok_p;
   logic             bad_p;
   logic [1:0]       strip;
   logic             shot_run;
   logic [31:0]      q;
   logic             e;
   logic [7:0]       sum;
   int               bad_count;
   int               checks;
   int               cyc = 0;
   logic [7:0]       pay [10] = '{8'h33, 8'h32, 8'h34, 8'h3a, 8'h30,
                                  8'h31, 8'h33, 8'h30, 8'h31, 8'h32};

   // Released bus rests high through the line bias
   assign line = line_oe ? line_out : 1'b1;

   // Flash phase stays on for the whole run, so the sent separator is known
   sbpr_console_tx #(.FLASH_CYCLES(1000000)) u_dut (
      .clk      (clk),
      .resetn   (resetn),
      .apb_req  (req),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .line_out (line_out),
      .line_oe  (line_oe)
   );

   sbpr_rx_model u_rx (
      .clk      (clk),
      .line     (line),
      .ok_p     (ok_p),
      .bad_p    (bad_p),
      .strip    (strip),
      .shot_run (shot_run)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic test_done();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // One packet lasts about 69k cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         bad_count++;
         test_done();
      end
   end

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
      checks++;
      if (got !== x) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, x, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      req <= '0;
      chk("pready", 32'h1, 32'(pready));
   endtask

   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      chk(nm, x, q);
      chk("rd_pslverr", 32'(xe), 32'(e));
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
      apb(1'b1, a, d);
      chk("wr_pslverr", 32'(xe), 32'(e));
   endtask

   initial begin
      resetn = 1'b0;
      req = '0;
      bad_count = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      rd("ctrl", REG_CTRL, 32'h0, 1'b0);
      rd("status", REG_STATUS, 32'h0, 1'b0);
      rd("pay1_w0", REG_PAY1, 32'h20202020, 1'b0);
      rd("unmapped", 12'h00c, 32'h0, 1'b1);
      chk("line_rest", 32'h1, {30'h0, line_oe, line_out});
      wr(12'h0fc, 32'h1, 1'b1);
      wr(REG_STATUS, 32'hffffffff, 1'b0);
      // Stored separator is blank; the timeout flash must override it
      wr(REG_PAY1, 32'h20343233, 1'b0);
      wr(REG_PAY1 + 12'h004, 32'hb0b3b1b0, 1'b0);
      wr(REG_PAY1 + 12'h008, 32'hffffb2b1, 1'b0);
      rd("pay1_w1", REG_PAY1 + 12'h004, 32'h30333130, 1'b0);
      rd("pay1_w2", REG_PAY1 + 12'h008, 32'h00003231, 1'b0);
      wr(REG_URGENT, 32'h2, 1'b0);
      wr(REG_CTRL, 32'h5, 1'b0);
      rd("ctrl_rb", REG_CTRL, 32'h5, 1'b0);
      for (int i = 0; i < 80000 && ok_p !== 1'b1 && bad_p !== 1'b1; i++) @(posedge clk);
      chk("pkt_ok", 32'h1, 32'(ok_p));
      chk("addr", 32'(ADDR_SC), 32'(u_rx.pkt[0]));
      sum = ADDR_SC;
      for (int k = 0; k < 10; k++) begin
         sum = sum + pay[k];
         chk("payload", 32'(pay[k]), 32'(u_rx.pkt[k + 1]));
      end
      chk("check_byte", 32'(sum & 8'h7f), 32'(u_rx.pkt[11]));
      chk("strip", 32'h2, 32'(strip));
      chk("shot_run", 32'h1, 32'(shot_run));
      chk("yel_tenths", 32'h3, 32'(u_rx.yel_tenths));
      chk("to_sep", 32'h1, 32'(u_rx.to_sep));
      chk("shot_seg_hi", 32'h5b, 32'(u_rx.shot_seg[0]));
      chk("shot_seg_lo", 32'h66, 32'(u_rx.shot_seg[1]));
      chk("blank", 32'h0, 32'(u_rx.blank));
      for (int i = 0; i < 2000 && line_oe !== 1'b0; i++) @(posedge clk);
      chk("line_end", 32'h1, {30'h0, line_oe, line_out});
      rd("status_end", REG_STATUS, 32'h00010001, 1'b0);
      rd("urgent_end", REG_URGENT, 32'h0, 1'b0);
      test_done();
   end
endmodule // test_sbpr_console_tx

`default_nettype wire
